// >>> pkg/ssac_cfg.svh
// Constants of the converter control block
// Contract
// - A trigger rising edge samples all eight channels at once.
// - Busy rises on the trigger edge and falls after all channels converted.
// - Busy falling ends the conversion set and starts the next acquisition.
// - A trigger rising edge while busy starts nothing new, except the next sample when trigger pacing is on.
// - New results are readable only after busy falls; host waits for it.
// - While busy, the previous results stay readable.
// - Internal timer paces conversion; software mode may use trigger as clock.
// - All channels convert every cycle and all appear in readback.
// - Bipolar ranges give twos complement, unipolar ranges straight binary.
// - Each result is an 18-bit code, one step is range over 262144.
// - Reference select high enables the internal reference, low disables it.
// - After reset the reference mode follows the select pin level.
// - Pins 000 mean no oversampling, 001 to 110 give 2 to 64.
// - Pins 111 enter software mode, configured through registers.
// - Reference and interface type come only from their pins.
// - Highest ratio is 64 in hardware mode, 256 in software mode.
// - Hardware mode uses two data lines; software selects 1, 2, 4, 8.
// - Autostandby power mode exists only in software mode.
// - Calibration, open circuit detection, diagnostics only in software mode.
// - Software mode offers unipolar 0-12.5, 0-10, 0-5 and bipolar ranges.
// - Software mode sets each channel range by registers 0x03 to 0x06.
// - Hardware mode latches the ratio pins at busy falling and reset.
// - Software mode takes the ratio from register 0x08, adding 128, 256.
`ifndef SSAC_CFG_SVH
`define SSAC_CFG_SVH
`define SSAC_IDX_STATUS 8'h01
`define SSAC_IDX_CONFIG 8'h02
`define SSAC_IDX_RANGE_FIRST 8'h03
`define SSAC_IDX_RANGE_LAST 8'h06
`define SSAC_IDX_OSR 8'h08
`define SSAC_IDX_RESULT_FIRST 8'h10
`define SSAC_IDX_RESULT_LAST 8'h17
`define SSAC_CFG_RESET 8'h04
`define SSAC_RANGE_RESET 8'h33
`define SSAC_CFG_PWR_LSB 0
`define SSAC_CFG_LINES_LSB 2
`define SSAC_CFG_EXTCLK_BIT 4
`define SSAC_CFG_CAL_BIT 5
`define SSAC_CFG_OPEN_BIT 6
`define SSAC_CFG_DIAG_BIT 7
`define SSAC_RES_W 18
`define SSAC_OSR_MAX_HW 4'h6
`define SSAC_OSR_MAX_SW 4'h8
`define SSAC_LINES_HW 2'h1
`define SSAC_CLK_MHZ 125
`define SSAC_T_SAMPLE_NS 800
`define SSAC_SAMPLE_CYC ((`SSAC_T_SAMPLE_NS * `SSAC_CLK_MHZ + 999) / 1000)
`endif

// >>> pkg/ssac_pkg.sv
// Types of the converter control block
`default_nettype none
package ssac_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_WAIT = 2'h3
	} ssac_state_t;
	typedef enum logic [1:0] {
		PWR_NORMAL = 2'h0,
		PWR_STANDBY = 2'h1,
		PWR_AUTO = 2'h2,
		PWR_SHUTDOWN = 2'h3
	} ssac_pwr_t;
	// Per channel range codes; 5 to 7 are the unipolar ones
	typedef enum logic [3:0] {
		RNG_PM2P5 = 4'h0,
		RNG_PM5 = 4'h1,
		RNG_PM6P25 = 4'h2,
		RNG_PM10 = 4'h3,
		RNG_PM12P5 = 4'h4,
		RNG_U5 = 4'h5,
		RNG_U10 = 4'h6,
		RNG_U12P5 = 4'h7,
		RNG_D5 = 4'h8,
		RNG_D10 = 4'h9,
		RNG_D12P5 = 4'hA,
		RNG_D20 = 4'hB
	} ssac_range_t;
endpackage
`default_nettype wire

// >>> design/ssac_ctrl.sv
// Conversion control, mode decoding and register slave of the converter
//
// Chosen here: the AHB-Lite register port and the register offsets.
`include "ssac_cfg.svh"
`default_nettype none
module ssac_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic conversion_trigger,
	input wire logic oversample_select_msb,
	input wire logic oversample_select_mid,
	input wire logic oversample_select_lsb,
	input wire logic reference_source_select,
	input wire logic interface_type_select,
	input wire logic range_pin,
	input wire logic standby_pin,
	input wire logic [143:0] sar_codes,
	output logic busy,
	output logic sample_strobe,
	output logic internal_ref_enable,
	output logic parallel_mode,
	output logic software_mode,
	output logic [3:0] osr_log2,
	output logic [1:0] serial_lines_code,
	output logic [1:0] power_mode,
	output logic analog_standby,
	output logic cal_enable,
	output logic open_detect_enable,
	output logic diag_enable
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic is_bipolar(input logic [3:0] rng);
		is_bipolar = !(rng == ssac_pkg::RNG_U5 || rng == ssac_pkg::RNG_U10 || rng == ssac_pkg::RNG_U12P5);
	endfunction

	// Analog core delivers offset binary; bipolar needs the sign flipped
	function automatic logic [17:0] code_result(input logic [17:0] raw, input logic bip);
		code_result = bip ? {~raw[17], raw[16:0]} : raw;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [7:0] pin_meta_q;
	logic [7:0] pin_q;
	logic trig_prev_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta_q <= 8'h00;
			pin_q <= 8'h00;
			trig_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= {standby_pin, range_pin, interface_type_select, reference_source_select,
				oversample_select_msb, oversample_select_mid, oversample_select_lsb, conversion_trigger};
			pin_q <= pin_meta_q;
			trig_prev_q <= pin_q[0];
		end
	end
	logic trig_rise;
	logic [2:0] os_pins;
	assign trig_rise = pin_q[0] && !trig_prev_q;
	assign os_pins = pin_q[3:1];

	// ----------------------------------------
	// Reset release capture
	// ----------------------------------------
	logic [1:0] boot_cnt_q;
	logic boot_latch;
	logic boot_done;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_cnt_q <= 2'h0;
		end else if (boot_cnt_q != 2'h3) begin
			boot_cnt_q <= boot_cnt_q + 2'h1;
		end
	end
	assign boot_latch = (boot_cnt_q == 2'h2);
	assign boot_done = (boot_cnt_q == 2'h3);

	logic sw_mode_q;
	logic parallel_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_mode_q <= 1'b0;
			parallel_q <= 1'b0;
		end else if (boot_latch) begin
			sw_mode_q <= (os_pins == 3'h7);
			parallel_q <= !pin_q[5];
		end
	end
	assign software_mode = sw_mode_q;
	assign parallel_mode = parallel_q;

	logic ref_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= pin_q[4];
		end
	end
	assign internal_ref_enable = ref_q;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] range_q [4];
	logic [3:0] osr_reg_q;
	logic [17:0] results_q [8];
	logic wr_pend_q;
	logic [7:0] wr_idx_q;
	logic addr_ok;
	logic [7:0] a_idx;
	logic [3:0] osr_log2_q;
	logic busy_q;
	assign a_idx = haddr[9:2];
	assign addr_ok = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_idx_q <= a_idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= `SSAC_CFG_RESET;
			osr_reg_q <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				range_q[i] <= `SSAC_RANGE_RESET;
			end
		end else if (wr_pend_q && sw_mode_q) begin
			if (wr_idx_q == `SSAC_IDX_CONFIG) begin
				cfg_q <= hwdata[7:0];
			end
			if (wr_idx_q == `SSAC_IDX_OSR) begin
				osr_reg_q <= hwdata[3:0];
			end
			for (int i = 0; i < 4; i++) begin
				if (wr_idx_q == `SSAC_IDX_RANGE_FIRST + 8'(i)) begin
					range_q[i] <= hwdata[7:0];
				end
			end
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (a_idx == `SSAC_IDX_STATUS) begin
			rd_mux = {24'h000000, osr_log2_q, parallel_q, ref_q, sw_mode_q, busy_q};
		end else if (a_idx == `SSAC_IDX_CONFIG) begin
			rd_mux = {24'h000000, cfg_q};
		end else if (a_idx == `SSAC_IDX_OSR) begin
			rd_mux = {28'h0000000, osr_reg_q};
		end else if (a_idx >= `SSAC_IDX_RANGE_FIRST && a_idx <= `SSAC_IDX_RANGE_LAST) begin
			rd_mux = {24'h000000, range_q[2'(a_idx - `SSAC_IDX_RANGE_FIRST)]};
		end else if (a_idx >= `SSAC_IDX_RESULT_FIRST && a_idx <= `SSAC_IDX_RESULT_LAST) begin
			rd_mux = {14'h0000, results_q[3'(a_idx - `SSAC_IDX_RESULT_FIRST)]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= (addr_ok && !hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------
	// Mode decoding
	// ----------------------------------------
	logic done_pulse;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osr_log2_q <= 4'h0;
		end else if (sw_mode_q) begin
			osr_log2_q <= (osr_reg_q > `SSAC_OSR_MAX_SW) ? `SSAC_OSR_MAX_SW : osr_reg_q;
		end else if (boot_latch || done_pulse) begin
			osr_log2_q <= (os_pins == 3'h7) ? 4'h0 : {1'b0, os_pins};
		end
	end
	assign osr_log2 = osr_log2_q;

	logic [1:0] lines_q;
	logic [1:0] pwr_q;
	logic cal_q;
	logic open_q;
	logic diag_q;
	logic ext_clk_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lines_q <= `SSAC_LINES_HW;
			pwr_q <= ssac_pkg::PWR_NORMAL;
			cal_q <= 1'b0;
			open_q <= 1'b0;
			diag_q <= 1'b0;
			ext_clk_q <= 1'b0;
		end else if (sw_mode_q) begin
			lines_q <= cfg_q[`SSAC_CFG_LINES_LSB +: 2];
			pwr_q <= cfg_q[`SSAC_CFG_PWR_LSB +: 2];
			cal_q <= cfg_q[`SSAC_CFG_CAL_BIT];
			open_q <= cfg_q[`SSAC_CFG_OPEN_BIT];
			diag_q <= cfg_q[`SSAC_CFG_DIAG_BIT];
			ext_clk_q <= cfg_q[`SSAC_CFG_EXTCLK_BIT];
		end else begin
			lines_q <= `SSAC_LINES_HW;
			pwr_q <= pin_q[7] ? ssac_pkg::PWR_NORMAL
				: (pin_q[6] ? ssac_pkg::PWR_STANDBY : ssac_pkg::PWR_SHUTDOWN);
			cal_q <= 1'b0;
			open_q <= 1'b0;
			diag_q <= 1'b0;
			ext_clk_q <= 1'b0;
		end
	end
	assign serial_lines_code = lines_q;
	assign power_mode = pwr_q;
	assign cal_enable = cal_q;
	assign open_detect_enable = open_q;
	assign diag_enable = diag_q;

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	ssac_pkg::ssac_state_t state_q;
	logic strobe_q;
	logic [7:0] timer_q;
	logic [8:0] left_q;
	logic [17:0] last_q [8];
	logic sample_end;
	assign sample_end = (state_q == ssac_pkg::ST_CONV) && (timer_q == 8'h01);
	assign done_pulse = sample_end && (left_q == 9'h001);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ssac_pkg::ST_IDLE;
			busy_q <= 1'b0;
			strobe_q <= 1'b0;
			timer_q <= 8'h00;
			left_q <= 9'h000;
		end else begin
			strobe_q <= 1'b0;
			case (state_q)
				ssac_pkg::ST_IDLE: begin
					if (trig_rise && boot_done) begin
						state_q <= ssac_pkg::ST_CONV;
						busy_q <= 1'b1;
						strobe_q <= 1'b1;
						timer_q <= 8'(`SSAC_SAMPLE_CYC);
						left_q <= 9'h001 << osr_log2_q;
					end
				end
				ssac_pkg::ST_CONV: begin
					if (done_pulse) begin
						state_q <= ssac_pkg::ST_IDLE;
						busy_q <= 1'b0;
					end else if (sample_end) begin
						left_q <= left_q - 9'h001;
						if (ext_clk_q) begin
							state_q <= ssac_pkg::ST_WAIT;
						end else begin
							strobe_q <= 1'b1;
							timer_q <= 8'(`SSAC_SAMPLE_CYC);
						end
					end else begin
						timer_q <= timer_q - 8'h01;
					end
				end
				ssac_pkg::ST_WAIT: begin
					if (trig_rise) begin
						state_q <= ssac_pkg::ST_CONV;
						strobe_q <= 1'b1;
						timer_q <= 8'(`SSAC_SAMPLE_CYC);
					end
				end
				default: begin
					state_q <= ssac_pkg::ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end
	assign busy = busy_q;
	assign sample_strobe = strobe_q;

	// Samples are taken from the core at the end of each conversion step
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 8; i++) begin
				last_q[i] <= 18'h00000;
			end
		end else if (sample_end) begin
			for (int i = 0; i < 8; i++) begin
				last_q[i] <= sar_codes[i * 18 +: 18];
			end
		end
	end

	logic [3:0] ch_range [8];
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			ch_range[i] = sw_mode_q ? range_q[i / 2][(i % 2) * 4 +: 4]
				: (pin_q[6] ? ssac_pkg::RNG_PM10 : ssac_pkg::RNG_PM5);
		end
	end

	// Output register only moves as busy falls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 8; i++) begin
				results_q[i] <= 18'h00000;
			end
		end else if (done_pulse) begin
			for (int i = 0; i < 8; i++) begin
				results_q[i] <= code_result(sar_codes[i * 18 +: 18], is_bipolar(ch_range[i]));
			end
		end
	end

	logic standby_pin_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			standby_pin_q <= 1'b0;
		end else if (pwr_q == ssac_pkg::PWR_AUTO) begin
			if (trig_rise) begin
				standby_pin_q <= 1'b0;
			end else if (done_pulse) begin
				standby_pin_q <= 1'b1;
			end
		end else begin
			standby_pin_q <= (pwr_q != ssac_pkg::PWR_NORMAL);
		end
	end
	assign analog_standby = standby_pin_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [17:0] exp0;
	assign exp0 = code_result(sar_codes[17:0], is_bipolar(ch_range[0]));

	busy_rise_a: assert property (state_q == ssac_pkg::ST_IDLE && trig_rise && boot_done |=> busy_q && strobe_q)
		else $error("busy or strobe missing after trigger");
	busy_fall_a: assert property ($fell(busy_q) |-> $past(left_q) == 9'h001 && $past(sample_end))
		else $error("busy fell before last sample");
	trig_ignore_a: assert property (busy_q && trig_rise && !ext_clk_q && !sample_end |=> !strobe_q)
		else $error("trigger during busy started a sample");
	result_hold_a: assert property ($changed(results_q[0]) |-> $fell(busy_q))
		else $error("results moved while not finishing");
	result_code_a: assert property (done_pulse |=> results_q[0] == $past(exp0))
		else $error("result coding wrong");
	ref_follow_a: assert property (boot_done |-> internal_ref_enable == $past(reference_source_select, 3))
		else $error("reference enable does not follow pin");
	osr_limit_a: assert property (osr_log2_q <= (sw_mode_q ? `SSAC_OSR_MAX_SW : `SSAC_OSR_MAX_HW))
		else $error("ratio above mode limit");
	hw_lines_a: assert property (!sw_mode_q |-> lines_q == `SSAC_LINES_HW)
		else $error("hardware mode line count wrong");
	hw_power_a: assert property (!sw_mode_q |-> pwr_q != ssac_pkg::PWR_AUTO)
		else $error("autostandby in hardware mode");
	hw_feat_a: assert property (!sw_mode_q |-> !cal_q && !open_q && !diag_q)
		else $error("software feature active in hardware mode");
	osr_latch_a: assert property (!sw_mode_q && $changed(osr_log2_q) |-> $fell(busy_q) || $past(boot_latch))
		else $error("ratio changed outside latch points");

	conv_done_c: cover property ($fell(busy_q));
	trig_busy_c: cover property (busy_q && trig_rise);
	ext_wait_c: cover property (state_q == ssac_pkg::ST_WAIT ##[1:50] strobe_q);
	auto_standby_pin_c: cover property (pwr_q == ssac_pkg::PWR_AUTO && $rose(standby_pin_q));
endmodule
`default_nettype wire

// >>> tb/ssac_host.sv
// Host side model that pulses the conversion trigger and flags readable results
`default_nettype none
module ssac_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic fire,
	input wire logic busy,
	output logic conversion_trigger,
	output logic data_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic busy_q;
	// Trigger high four cycles, then low at least four before the next
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
			conversion_trigger <= 1'b0;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			conversion_trigger <= cnt_q > 4'h5;
		end else if (fire) begin
			cnt_q <= 4'h8;
			conversion_trigger <= 1'b1;
		end
	end
	// New results are only taken once busy has fallen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
			data_ready <= 1'b0;
		end else begin
			busy_q <= busy;
			if (busy_q && !busy) begin
				data_ready <= 1'b1;
			end else if (fire) begin
				data_ready <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the converter control block
`include "ssac_cfg.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] pins;
		logic rf;
		logic it;
		logic sw;
		logic [3:0] lg;
	} ssac_row_t;
	ssac_row_t rows [8] = '{
		'{3'h0, 1'b1, 1'b1, 1'b0, 4'h0}, '{3'h1, 1'b0, 1'b0, 1'b0, 4'h1},
		'{3'h2, 1'b1, 1'b0, 1'b0, 4'h2}, '{3'h3, 1'b0, 1'b1, 1'b0, 4'h3},
		'{3'h4, 1'b1, 1'b1, 1'b0, 4'h4}, '{3'h5, 1'b0, 1'b0, 1'b0, 4'h5},
		'{3'h6, 1'b1, 1'b1, 1'b0, 4'h6}, '{3'h7, 1'b0, 1'b0, 1'b1, 4'h0}
	};
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, fire, data_ready, conversion_trigger, hreadyout;
	logic reference_source_select, interface_type_select, range_pin, standby_pin;
	logic busy, sample_strobe, internal_ref_enable, parallel_mode, software_mode;
	logic analog_standby, cal_enable, open_detect_enable, diag_enable, have_prev, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, serial_lines_code, power_mode;
	logic [2:0] hsize, sel_pins;
	logic [3:0] osr_log2;
	logic [143:0] sar_codes;
	logic [14:0] pat;
	logic [31:0] prev_e [8];
	int bad_count, checks, cyc, bcyc, scnt;
	ssac_ctrl dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .conversion_trigger, .oversample_select_msb(sel_pins[2]),
		.oversample_select_mid(sel_pins[1]), .oversample_select_lsb(sel_pins[0]), .reference_source_select,
		.interface_type_select, .range_pin, .standby_pin, .sar_codes, .busy, .sample_strobe, .internal_ref_enable,
		.parallel_mode, .software_mode, .osr_log2, .serial_lines_code, .power_mode, .analog_standby, .cal_enable,
		.open_detect_enable, .diag_enable
	);
	ssac_host host (.hclk, .hresetn, .fire, .busy, .conversion_trigger, .data_ready);
	always #4 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (busy === 1'b1) bcyc++;
		if (sample_strobe === 1'b1) scnt++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	// --------------------------------------------------
	// Bus and check tasks
	// --------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, idx, 32'h00000000, x);
		chk(nm, x, exp);
	endtask
	task automatic do_reset(input logic [2:0] p);
		hresetn <= 1'b0;
		sel_pins <= p;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (5) @(posedge hclk);
		have_prev = 1'b0;
	endtask
	task automatic conv(input int lg, input logic [7:0] uni, input logic [2:0] nxt, input logic [3:0] lg_after);
		@(negedge hclk);
		bcyc = 0;
		scnt = 0;
		@(posedge hclk);
		for (int i = 0; i < 8; i++) sar_codes[18 * i +: 18] <= {pat, 3'(i)};
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (20) @(posedge hclk);
		fire <= 1'b1;
		sel_pins <= nxt;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (4) @(posedge hclk);
		chk("ratio_mid", osr_log2, 32'(lg));
		for (int i = 0; i < 8 && have_prev; i++) rdc("prev", `SSAC_IDX_RESULT_FIRST + 8'(i), prev_e[i]);
		while (data_ready !== 1'b1) @(posedge hclk);
		repeat (2) @(posedge hclk);
		chk("busy_cycles", bcyc, `SSAC_SAMPLE_CYC << lg);
		chk("strobes", scnt, 1 << lg);
		chk("ratio_after", osr_log2, lg_after);
		for (int i = 0; i < 8; i++) begin
			prev_e[i] = {14'h0000, pat[14] ^ !uni[i], pat[13:0], 3'(i)};
			rdc("result", `SSAC_IDX_RESULT_FIRST + 8'(i), prev_e[i]);
		end
		have_prev = 1'b1;
		pat = ~pat;
	endtask
	// --------------------------------------------------
	// Main sequence
	// --------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		fire = 1'b0;
		sel_pins = 3'h0;
		reference_source_select = 1'b1;
		interface_type_select = 1'b1;
		range_pin = 1'b1;
		standby_pin = 1'b1;
		sar_codes = 144'h0;
		pat = 15'h4A53;
		have_prev = 1'b0;
		foreach (rows[k]) begin
			reference_source_select <= rows[k].rf;
			interface_type_select <= rows[k].it;
			do_reset(rows[k].pins);
			chk("software_mode", software_mode, rows[k].sw);
			if (!rows[k].sw) chk("ratio", osr_log2, rows[k].lg);
			chk("internal_ref", internal_ref_enable, rows[k].rf);
			chk("parallel", parallel_mode, !rows[k].it);
			chk("lines", serial_lines_code, 2'h1);
			chk("sw_features", {cal_enable, open_detect_enable, diag_enable}, 3'h0);
		end
		reference_source_select <= 1'b1;
		interface_type_select <= 1'b0;
		do_reset(3'h0);
		conv(0, 8'h00, 3'h1, 4'h1);
		conv(1, 8'h00, 3'h0, 4'h0);
		wr(`SSAC_IDX_CONFIG, 32'h000000EE);
		rdc("config_hw", `SSAC_IDX_CONFIG, `SSAC_CFG_RESET);
		rdc("unmapped", 8'h07, 32'h00000000);
		chk("response", {hreadyout, hresp}, 2'h2);
		standby_pin <= 1'b0;
		reference_source_select <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("power_hw", power_mode, 2'h1);
		chk("internal_ref", internal_ref_enable, 1'b0);
		range_pin <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("power_hw", power_mode, 2'h3);
		standby_pin <= 1'b1;
		do_reset(3'h7);
		wr(`SSAC_IDX_CONFIG, 32'h000000EE);
		rdc("config", `SSAC_IDX_CONFIG, 32'h000000EE);
		chk("power", power_mode, 2'h2);
		chk("lines", serial_lines_code, 2'h3);
		chk("sw_features", {cal_enable, open_detect_enable, diag_enable}, 3'h7);
		wr(`SSAC_IDX_OSR, 32'h00000009);
		repeat (2) @(posedge hclk);
		chk("ratio_max", osr_log2, `SSAC_OSR_MAX_SW);
		rdc("status", `SSAC_IDX_STATUS, 32'h0000008A);
		wr(`SSAC_IDX_OSR, 32'h00000001);
		wr(`SSAC_IDX_RANGE_FIRST, 32'h00000077);
		conv(1, 8'h03, 3'h7, 4'h1);
		chk("auto_standby", analog_standby, 1'b1);
		// External pacing: the second sample waits for another trigger edge
		wr(`SSAC_IDX_CONFIG, 32'h00000010);
		scnt = 0;
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (150) @(posedge hclk);
		chk("ext_wait", {busy, scnt[1:0]}, 3'h5);
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		while (data_ready !== 1'b1) @(posedge hclk);
		chk("ext_strobes", scnt, 32'h00000002);
		final_report();
	end
endmodule
`default_nettype wire
